// File: verilog/plcst_pkg.sv
// Purpose: constants and types for the operating-state controller
// Assumes: one clock at 50 MHz, synchronous active-low reset
// Notes: register map is reached over APB, 32-bit aligned words
package plcst_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DIAG   = 8'h0C;
   localparam logic [7:0] ADDR_ACTION = 8'h10;

   localparam int CTRL_START_HALT = 0;
   localparam int CTRL_REMOTE_EN  = 1;
   localparam int CTRL_SLAVE_MODE = 2;

   localparam int CMD_PC_HALT = 0;
   localparam int CMD_PC_RUN  = 1;
   localparam int CMD_PC_COLD = 2;
   localparam int CMD_XFER    = 3;
   localparam int CMD_ERR_ACK = 4;

   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [7:0] DIAG_RESET = 8'h00;

   localparam int DIAG_HW_ERR   = 0;
   localparam int DIAG_PRG_ERR  = 1;
   localparam int DIAG_COPY_DN  = 2;
   localparam int DIAG_UPDT_DN  = 3;
   localparam int DIAG_XFER_HLT = 4;

   typedef enum logic [1:0] {
      PLCST_SEL_HALT = 2'h0,
      PLCST_SEL_RUN  = 2'h1,
      PLCST_SEL_RUNM = 2'h2
   } plcst_sel_type;

   typedef enum logic [6:0] {
      PLCST_POWER = 7'h01,
      PLCST_TEST  = 7'h02,
      PLCST_CMP   = 7'h04,
      PLCST_READY = 7'h08,
      PLCST_RUN   = 7'h10,
      PLCST_FIN   = 7'h20,
      PLCST_STOP  = 7'h40
   } plcst_state_type;

   // action strobes to the program memory and data areas
   typedef struct packed {
      logic copy_to_ram;
      logic update_module;
      logic cold_clear;
      logic warm_start;
   } plcst_act_type;

   typedef struct packed {
      logic executing;
      logic ready;
      logic stopped;
   } plcst_mode_type;
endpackage : plcst_pkg

// File: verilog/plcst_apb.sv
// Purpose: APB slave for the state controller registers
// Assumes: zero wait states, 32-bit aligned registers
// Notes: writes to CMD produce one-cycle pulses; unmapped reads return zero with pslverr
`timescale 1ns/1ns
`default_nettype none
module plcst_apb
   import plcst_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output var  logic [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [31:0] status_i,
   input  wire logic [31:0] diag_i,
   input  wire logic [31:0] action_i,
   output var  logic [2:0]  ctrl_o,
   output var  logic [4:0]  cmd_o
);
   wire acc        = psel_i & penable_i & ce_i;
   wire wr         = acc & pwrite_i;
   wire hit_ctrl   = (paddr_i == ADDR_CTRL);
   wire hit_cmd    = (paddr_i == ADDR_CMD);
   wire hit_status = (paddr_i == ADDR_STATUS);
   wire hit_diag   = (paddr_i == ADDR_DIAG);
   wire hit_act    = (paddr_i == ADDR_ACTION);
   wire mapped     = hit_ctrl | hit_cmd | hit_status | hit_diag | hit_act;
   wire [31:0] rd_mux = hit_ctrl   ? {29'h0, ctrl_o} :
                        hit_status ? status_i :
                        hit_diag   ? diag_i :
                        hit_act    ? action_i : 32'h0;

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctrl_o   <= CTRL_RESET;
         cmd_o    <= 5'h00;
         prdata_o <= 32'h0;
      end else if (ce_i) begin
         cmd_o <= (wr & hit_cmd) ? pwdata_i[4:0] : 5'h00;
         if (wr & hit_ctrl) ctrl_o <= pwdata_i[2:0];
         if (psel_i & ~penable_i & ~pwrite_i) prdata_o <= rd_mux;
      end
   end
endmodule : plcst_apb
`default_nettype wire

// File: verilog/plcst_ctrl.sv
// Purpose: operating-state controller of the logic controller
// Assumes: button, power-up, flap and error inputs are synchronous one-cycle events
// Notes: program memories answer the compare through done/status handshakes
`timescale 1ns/1ns
`default_nettype none
module plcst_ctrl
   import plcst_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   input  wire logic          ce_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [7:0]    paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output var  logic [31:0]   prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   input  wire plcst_sel_type sel_i,
   input  wire logic          reset_btn_i,
   input  wire logic          power_up_i,
   input  wire logic          power_fail_i,
   input  wire logic          flap_i,
   input  wire logic          selftest_done_i,
   input  wire logic          selftest_fail_i,
   input  wire logic          hw_error_i,
   input  wire logic          prog_fault_i,
   input  wire logic          master_halt_i,
   input  wire logic          master_run_i,
   input  wire logic          cycle_end_i,
   input  wire logic          cmp_done_i,
   input  wire logic          cmp_differ_i,
   input  wire logic          module_bad_i,
   input  wire logic          ram_valid_i,
   input  wire logic          module_boot_i,
   output var  plcst_mode_type mode_o,
   output var  plcst_act_type  act_o,
   output var  logic          prog_exec_o,
   output var  logic          out_enable_o,
   output var  logic          out_clear_o,
   output var  logic          selftest_start_o,
   output var  logic          cmp_start_o
);
   plcst_state_type state_reg, state_next;
   logic [7:0]  diag_reg;
   logic        err_pend_reg;
   logic        cold_reg;
   logic        fin_to_run_reg;
   logic        run_req_reg;
   logic [2:0]  ctrl;
   logic [4:0]  cmd;

   plcst_apb u_apb (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .prdata_o  (prdata_o),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .status_i  ({25'h0, state_reg}),
      .diag_i    ({24'h0, diag_reg}),
      .action_i  ({28'h0, act_o}),
      .ctrl_o    (ctrl),
      .cmd_o     (cmd)
   );

   wire start_halt = ctrl[CTRL_START_HALT];
   wire remote_ok  = ctrl[CTRL_SLAVE_MODE] & ctrl[CTRL_REMOTE_EN];
   wire rem_halt   = remote_ok & master_halt_i;
   wire rem_run    = remote_ok & master_run_i & ~master_halt_i;
   wire pc_halt    = cmd[CMD_PC_HALT];
   wire pc_run     = cmd[CMD_PC_RUN];
   wire pc_cold    = cmd[CMD_PC_COLD];
   wire pc_xfer    = cmd[CMD_XFER];
   wire err_ack    = cmd[CMD_ERR_ACK] | reset_btn_i;
   wire sel_halt   = (sel_i == PLCST_SEL_HALT);
   wire sel_runm   = (sel_i == PLCST_SEL_RUNM);
   wire fault_in   = hw_error_i | prog_fault_i;
   wire halt_boot  = start_halt & (pc_xfer | module_boot_i);
   // acknowledge leaves stopped only once no fault is still pending
   wire err_clear  = ~err_pend_reg & ~fault_in;
   wire run_start  = reset_btn_i & ~sel_halt | pc_run | pc_cold | rem_run;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PLCST_POWER: state_next = PLCST_TEST;
         PLCST_TEST:
            if (selftest_done_i)
               state_next = selftest_fail_i ? PLCST_STOP : PLCST_CMP;
         PLCST_CMP:
            if (cmp_done_i)
               state_next = (sel_halt & ~run_req_reg) ? PLCST_READY : PLCST_RUN;
         PLCST_READY:
            if (run_start) state_next = PLCST_CMP;
         PLCST_RUN:
            if ((reset_btn_i & sel_halt) | pc_halt | rem_halt | flap_i)
               state_next = PLCST_READY;
         PLCST_FIN:
            if (cycle_end_i) state_next = fin_to_run_reg ? PLCST_RUN : PLCST_READY;
         PLCST_STOP:
            if (err_ack & err_clear)
               state_next = sel_halt & reset_btn_i ? PLCST_READY : PLCST_CMP;
         default: state_next = PLCST_POWER;
      endcase
      if (flap_i & (state_reg != PLCST_STOP)) state_next = PLCST_READY;
      if (fault_in) state_next = PLCST_STOP;
      if (halt_boot) state_next = PLCST_STOP;
      if (power_up_i)
         state_next = (state_reg == PLCST_RUN) & ~sel_runm ? PLCST_FIN :
                      (state_reg == PLCST_STOP) & ~sel_runm & ~err_clear ? PLCST_STOP :
                      PLCST_TEST;
      if (power_fail_i) state_next = PLCST_POWER;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg      <= PLCST_POWER;
         diag_reg       <= DIAG_RESET;
         err_pend_reg   <= 1'b0;
         cold_reg       <= 1'b0;
         fin_to_run_reg <= 1'b0;
         run_req_reg    <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         // fault latch: set wins over acknowledge
         err_pend_reg <= fault_in | (err_pend_reg & ~(err_ack & ~hw_error_i));
         if (power_up_i) fin_to_run_reg <= ~sel_halt;
         // run request kept across the compare
         // command pulses are gone by the time the compare ends
         if (state_reg != PLCST_CMP) run_req_reg <= pc_run | pc_cold | rem_run;
         if ((power_up_i & sel_runm) |
             ((state_reg == PLCST_READY | state_reg == PLCST_STOP) &
              ((reset_btn_i & sel_runm) | pc_cold)))
            cold_reg <= 1'b1;
         else if (state_reg == PLCST_RUN)
            cold_reg <= 1'b0;
         if (reset_btn_i | cmd[CMD_ERR_ACK])
            diag_reg <= DIAG_RESET;
         diag_reg[DIAG_HW_ERR]   <= hw_error_i | selftest_fail_i |
                                    (diag_reg[DIAG_HW_ERR] & ~err_ack);
         diag_reg[DIAG_PRG_ERR]  <= prog_fault_i | (diag_reg[DIAG_PRG_ERR] & ~err_ack);
         diag_reg[DIAG_COPY_DN]  <= act_o.copy_to_ram | (diag_reg[DIAG_COPY_DN] & ~err_ack);
         diag_reg[DIAG_UPDT_DN]  <= act_o.update_module | (diag_reg[DIAG_UPDT_DN] & ~err_ack);
         diag_reg[DIAG_XFER_HLT] <= halt_boot | (diag_reg[DIAG_XFER_HLT] & ~err_ack);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mode_o           <= '0;
         act_o            <= '0;
         prog_exec_o      <= 1'b0;
         out_enable_o     <= 1'b0;
         out_clear_o      <= 1'b1;
         selftest_start_o <= 1'b0;
         cmp_start_o      <= 1'b0;
      end else if (ce_i) begin
         mode_o.executing <= (state_next == PLCST_RUN) | (state_next == PLCST_FIN);
         mode_o.stopped   <= (state_next == PLCST_STOP);
         mode_o.ready     <= ~((state_next == PLCST_RUN) | (state_next == PLCST_FIN) |
                               (state_next == PLCST_STOP));
         prog_exec_o  <= (state_next == PLCST_RUN) | (state_next == PLCST_FIN);
         // outputs cleared for the finishing cycle, like a warm restart
         out_enable_o <= (state_next == PLCST_RUN);
         out_clear_o  <= (state_next != PLCST_RUN);
         selftest_start_o <= (state_reg != PLCST_TEST) & (state_next == PLCST_TEST);
         cmp_start_o      <= (state_reg != PLCST_CMP) & (state_next == PLCST_CMP);
         act_o.copy_to_ram   <= (state_reg == PLCST_CMP) & cmp_done_i & cmp_differ_i & ~module_bad_i;
         act_o.update_module <= pc_xfer |
                                ((state_reg == PLCST_CMP) & cmp_done_i & module_bad_i & ram_valid_i);
         act_o.cold_clear    <= (state_reg != PLCST_RUN) & (state_next == PLCST_RUN) & cold_reg;
         act_o.warm_start    <= (state_reg != PLCST_RUN) & (state_next == PLCST_RUN) & ~cold_reg;
      end
   end

   a_ready_outputs_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      mode_o.ready |-> !out_enable_o && !prog_exec_o) else $error("ready with outputs on");
   a_fault_stops: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && fault_in && !power_fail_i && !power_up_i |=> mode_o.stopped)
      else $error("fault did not stop");
   // single state
   // mode_o still holds its all-zero reset value at the first edge after release
   a_one_state: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> $onehot({mode_o.executing, mode_o.ready, mode_o.stopped}))
      else $error("state not unique");
   a_flap_ready: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && flap_i && !fault_in && !halt_boot && !power_up_i && !power_fail_i
      && state_reg != PLCST_STOP |=> state_reg == PLCST_READY) else $error("flap ignored");
   a_halt_boot: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && halt_boot && !power_up_i && !power_fail_i |=> state_reg == PLCST_STOP)
      else $error("halt start ignored");
   a_xfer_update: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && pc_xfer |=> act_o.update_module) else $error("no module update");
   a_exec_state: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      prog_exec_o |-> (state_reg == PLCST_RUN || state_reg == PLCST_FIN))
      else $error("exec outside run");
   a_stop_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_STOP && err_pend_reg && !power_fail_i && !power_up_i
      |=> state_reg == PLCST_STOP) else $error("left stop with fault");
   a_selftest_fail: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_TEST && selftest_done_i && selftest_fail_i && !power_fail_i
      && !power_up_i |=> state_reg == PLCST_STOP) else $error("self-test fail ignored");
   a_remote_halt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_RUN && rem_halt && !fault_in && !halt_boot && !power_up_i
      && !power_fail_i |=> state_reg == PLCST_READY) else $error("remote halt ignored");
   a_reset_ack_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_RUN && reset_btn_i && !sel_halt && !pc_halt && !rem_halt
      && !flap_i && !fault_in && !halt_boot && !power_up_i && !power_fail_i
      |=> state_reg == PLCST_RUN && !diag_reg[DIAG_PRG_ERR]) else $error("run reset changed state");
   a_run_request: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_READY && (pc_run || pc_cold) && !flap_i && !fault_in
      && !halt_boot && !power_up_i && !power_fail_i |=> state_reg == PLCST_CMP && run_req_reg)
      else $error("start request lost");
   a_cmp_to_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && state_reg == PLCST_CMP && cmp_done_i && run_req_reg && !flap_i && !fault_in
      && !halt_boot && !power_up_i && !power_fail_i |=> state_reg == PLCST_RUN)
      else $error("compare did not run");
endmodule : plcst_ctrl
`default_nettype wire

// File: verification/plcst_partner.sv
// Purpose: model of the self-test logic and the program memories
// Assumes: each start pulse is answered lat_i+1 cycles later
// Notes: result levels are inverted outside the done pulse
`timescale 1ns/1ns
`default_nettype none
module plcst_partner (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       st_start_i,
   input  wire logic       cmp_start_i,
   input  wire logic [3:0] cfg_i,
   input  wire logic [3:0] lat_i,
   output logic            st_done_o,
   output logic            st_fail_o,
   output logic            cmp_done_o,
   output logic            differ_o,
   output logic            bad_o,
   output logic            valid_o
);
   logic [4:0] st_reg;
   logic [4:0] cm_reg;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_reg <= 5'h00;
         cm_reg <= 5'h00;
      end else begin
         st_reg <= st_start_i ? {1'b0, lat_i} + 5'h01 : st_reg - {4'h0, |st_reg};
         cm_reg <= cmp_start_i ? {1'b0, lat_i} + 5'h01 : cm_reg - {4'h0, |cm_reg};
      end
   end
   assign st_done_o  = (st_reg == 5'h01);
   assign cmp_done_o = (cm_reg == 5'h01);
   assign st_fail_o  = st_done_o ? cfg_i[3] : ~cfg_i[3];
   assign bad_o      = cmp_done_o ? cfg_i[2] : ~cfg_i[2];
   assign valid_o    = cmp_done_o ? cfg_i[1] : ~cfg_i[1];
   assign differ_o   = cmp_done_o ? cfg_i[0] : ~cfg_i[0];
endmodule : plcst_partner
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench for the operating-state controller
// Assumes: zero-wait APB, event inputs as one-cycle pulses
// Notes: cfg bits are fail, module bad, ram valid, differ
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import plcst_pkg::*;
   localparam int BTN = 0, PUP = 1, PFL = 2, FLAP = 3, HWE = 4;
   localparam int PFT = 5, MHL = 6, MRN = 7, CEND = 8, MBT = 9;
   localparam logic [2:0] RUN = 3'h4, RDY = 3'h2, STP = 3'h1;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pe, oe, oc, sts, cms, std, stf, cmd, dif, bad, val;
   logic saw_ready = 1'b0;
   logic [9:0] ev = 10'h000;
   logic [3:0] cfg = 4'h0, lat = 4'h0;
   plcst_sel_type sel = PLCST_SEL_HALT;
   plcst_mode_type mode;
   plcst_act_type act;
   int n_fail = 0, num_checks = 0, n_copy = 0, n_updt = 0, n_cold = 0;
   always #10 mclk_i = ~mclk_i;
   plcst_ctrl i_plcst_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sel_i(sel), .reset_btn_i(ev[BTN]), .power_up_i(ev[PUP]),
      .power_fail_i(ev[PFL]), .flap_i(ev[FLAP]), .selftest_done_i(std), .selftest_fail_i(stf),
      .hw_error_i(ev[HWE]), .prog_fault_i(ev[PFT]), .master_halt_i(ev[MHL]), .master_run_i(ev[MRN]),
      .cycle_end_i(ev[CEND]), .cmp_done_i(cmd), .cmp_differ_i(dif), .module_bad_i(bad),
      .ram_valid_i(val), .module_boot_i(ev[MBT]), .mode_o(mode), .act_o(act), .prog_exec_o(pe),
      .out_enable_o(oe), .out_clear_o(oc), .selftest_start_o(sts), .cmp_start_o(cms));
   plcst_partner i_plcst_partner (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .st_start_i(sts),
      .cmp_start_i(cms), .cfg_i(cfg), .lat_i(lat), .st_done_o(std), .st_fail_o(stf),
      .cmp_done_o(cmd), .differ_o(dif), .bad_o(bad), .valid_o(val));
   always @(posedge mclk_i) begin
      n_copy = n_copy + int'(act.copy_to_ram === 1'b1);
      n_updt = n_updt + int'(act.update_module === 1'b1);
      n_cold = n_cold + int'(act.cold_clear === 1'b1);
      if (mode.ready === 1'b1) saw_ready = 1'b1;
   end
   task automatic give_verdict();
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         n_fail++;
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk_i);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, {31'h0, pready});
   endtask : apb
   task automatic pulse(input int b);
      @(posedge mclk_i);
      ev[b] <= 1'b1;
      @(posedge mclk_i);
      ev[b] <= 1'b0;
   endtask : pulse
   task automatic clr();
      n_copy = 0;
      n_updt = 0;
      n_cold = 0;
      saw_ready = 1'b0;
   endtask : clr
   // polls status until the expected state shows, bounded; mode_o is ready in transient states too
   task automatic expect_st(input logic [2:0] m, input logic [31:0] code);
      int i;
      for (i = 0; i < 40; i++) begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         @(negedge mclk_i);
         if (rd === code && mode === m) break;
      end
      chk("mode_o", {29'h0, m}, {29'h0, mode});
      chk("status", code, rd);
      @(posedge mclk_i);
   endtask : expect_st
   task automatic stays(input logic [2:0] m);
      repeat (8) @(negedge mclk_i);
      chk("mode_o held", {29'h0, m}, {29'h0, mode});
      @(posedge mclk_i);
   endtask : stays
   task automatic cmd_wr(input int b);
      apb(1'b1, ADDR_CMD, 32'h1 << b);
   endtask : cmd_wr
   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      expect_st(RDY, 32'h08);
      chk("outputs", 32'h1, {29'h0, pe, oe, oc});
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", {29'h0, CTRL_RESET}, rd);
      cfg <= 4'h1;
      clr();
      cmd_wr(CMD_PC_RUN);
      expect_st(RUN, 32'h10);
      chk("copies", 32'h1, n_copy);
      chk("outputs", 32'h6, {29'h0, pe, oe, oc});
      sel <= PLCST_SEL_RUN;
      pulse(BTN);
      stays(RUN);
      sel <= PLCST_SEL_HALT;
      pulse(BTN);
      expect_st(RDY, 32'h08);
      cfg <= 4'h6;
      clr();
      sel <= PLCST_SEL_RUN;
      pulse(BTN);
      expect_st(RUN, 32'h10);
      chk("updates", 32'h1, n_updt);
      pulse(FLAP);
      expect_st(RDY, 32'h08);
      pulse(MRN);
      stays(RDY);
      apb(1'b1, ADDR_CTRL, 32'h6);
      pulse(MRN);
      expect_st(RUN, 32'h10);
      pulse(PFT);
      expect_st(STP, 32'h40);
      apb(1'b0, ADDR_DIAG, 32'h0);
      chk("diag prog", 32'h1, (rd >> DIAG_PRG_ERR) & 32'h1);
      cmd_wr(CMD_ERR_ACK);
      clr();
      pulse(BTN);
      expect_st(RUN, 32'h10);
      chk("via ready", 32'h1, {31'h0, saw_ready});
      pulse(MHL);
      expect_st(RDY, 32'h08);
      pulse(MRN);
      expect_st(RUN, 32'h10);
      sel <= PLCST_SEL_HALT;
      pulse(PUP);
      stays(RUN);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status fin", 32'h20, rd);
      pulse(CEND);
      expect_st(RDY, 32'h08);
      pulse(MRN);
      expect_st(RUN, 32'h10);
      sel <= PLCST_SEL_RUN;
      pulse(PUP);
      pulse(CEND);
      expect_st(RUN, 32'h10);
      pulse(HWE);
      expect_st(STP, 32'h40);
      sel <= PLCST_SEL_HALT;
      pulse(PUP);
      stays(STP);
      cmd_wr(CMD_ERR_ACK);
      clr();
      sel <= PLCST_SEL_RUNM;
      pulse(BTN);
      expect_st(RUN, 32'h10);
      chk("cold", 32'h1, n_cold);
      clr();
      pulse(BTN);
      stays(RUN);
      chk("no cold", 32'h0, n_cold);
      sel <= PLCST_SEL_HALT;
      pulse(BTN);
      expect_st(RDY, 32'h08);
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_START_HALT);
      clr();
      cmd_wr(CMD_XFER);
      expect_st(STP, 32'h40);
      chk("xfer upd", 32'h1, n_updt);
      cmd_wr(CMD_ERR_ACK);
      clr();
      cmd_wr(CMD_PC_COLD);
      expect_st(RUN, 32'h10);
      chk("pc cold", 32'h1, n_cold);
      cmd_wr(CMD_PC_HALT);
      expect_st(RDY, 32'h08);
      pulse(MBT);
      expect_st(STP, 32'h40);
      lat <= 4'h9;
      cfg <= 4'h8;
      pulse(PFL);
      expect_st(STP, 32'h40);
      chk("no exec", 32'h0, {31'h0, pe});
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
